// [rtl/charger_regs.vh]
// constants for the charger command and status logic: bus addresses, command codes, field positions,
// reset values and limits of the input-current-limit word.
// assumes a single 25 MHz device clock and a 16-bit word interface over the two-wire bus.
`ifndef CHARGER_REGS_VH
`define CHARGER_REGS_VH

// bus identity
`define SLAVE_ADDR            7'h09

// command codes
`define CMD_SPEC_INFO         8'h11
`define CMD_CHARGER_MODE      8'h12
`define CMD_STATE_FLAGS       8'h13
`define CMD_CHARGE_CURRENT    8'h14
`define CMD_CHARGE_VOLTAGE    8'h15
`define CMD_INPUT_LIMIT       8'h3F

// input-current-limit word, 1mA per step
`define ICL_CODE_LSB          7
`define ICL_CODE_MSB          12
`define ICL_MAX_MA            16'h2AFC
`define ICL_MIN_MA            16'h0100
`define ICL_RESET             16'h0100
`define ICL_CODE_MAX          6'h3F
`define ICL_CODE_MIN          6'h02

// other stored words
`define CHARGE_CURRENT_RESET  16'h0080
`define CHARGE_VOLTAGE_RESET  16'h0000
`define SPEC_INFO_VALUE       16'h0001

// status word bit positions
`define FLAG_ADAPTER_BIT      15
`define FLAG_BATTERY_BIT      14
`define FLAG_POWER_FAIL_BIT   13

`endif

// [rtl/charger_smbus_limit_status.v]
// two-wire bus slave with word registers, input-current-limit decode and supply/battery status flags.
// assumes comparator outputs arrive as asynchronous digital levels and that bus clock and data
// are sampled by clk_in, which must run at least eight times faster than the bus clock.
`timescale 1ns/1ps
`include "charger_regs.vh"

module charger_smbus_limit_status (
  // clock and reset
  input  wire       clk_in,
  input  wire       reset_n_in,
  // two-wire bus
  input  wire       scl_in,
  input  wire       sda_in,
  output reg        sda_out,
  output reg        sda_oe_out,
  // comparator levels
  input  wire       adapter_above_7v5_in,
  input  wire       adapter_below_battery_sense_in,
  input  wire       thermistor_below_91pct_in,
  input  wire       battery_sense_below_2v5_in,
  input  wire       battery_sense_above_2v7_in,
  input  wire       vdd_under_2v5_in,
  // converter controls and adapter-present flag
  output reg  [5:0] input_limit_code_out,
  output reg  [15:0] charge_current_word_out,
  output reg  [15:0] charge_voltage_word_out,
  output reg        charge_limit_128ma_out,
  output reg        charge_enable_out,
  output reg        source_switch_drive_out,
  output reg        adapter_present_flag_out
);

  localparam ST_IDLE = 5'b00001;
  localparam ST_RX   = 5'b00010;
  localparam ST_ACK  = 5'b00100;
  localparam ST_TX   = 5'b01000;
  localparam ST_MACK = 5'b10000;

  wire [7:0] pins_s;
  wire       scl_s;
  wire       sda_s;
  wire       adapter_ok_s;
  wire       power_fail_s;
  wire       thermistor_s;
  wire       battery_sense_low_s;
  wire       battery_sense_high_s;
  wire       vdd_uv_s;

  pin_sync #(
    .WIDTH (8)
  ) u_pin_sync (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .async_in   ({scl_in, sda_in, adapter_above_7v5_in, adapter_below_battery_sense_in,
                  thermistor_below_91pct_in, battery_sense_below_2v5_in, battery_sense_above_2v7_in, vdd_under_2v5_in}),
    .sync_out   (pins_s)
  );

  assign scl_s        = pins_s[7];
  assign sda_s        = pins_s[6];
  assign adapter_ok_s = pins_s[5];
  assign power_fail_s = pins_s[4];
  assign thermistor_s = pins_s[3];
  assign battery_sense_low_s   = pins_s[2];
  assign battery_sense_high_s  = pins_s[1];
  assign vdd_uv_s     = pins_s[0];

  // supply undervoltage holds all logic except the pin synchroniser in its reset state, so leaving it is a fresh power-on
  wire rst = !reset_n_in || vdd_uv_s;

  reg        scl_d_r;
  reg        sda_d_r;
  reg  [4:0] state_r;
  reg  [3:0] bit_cnt_r;
  reg  [1:0] byte_idx_r;
  reg  [7:0] shift_r;
  reg        read_r;
  reg        hi_sent_r;
  reg        mack_ok_r;
  reg  [7:0] cmd_r;
  reg  [7:0] data_lo_r;
  reg  [15:0] icl_word_r;
  reg  [15:0] tx_word_r;
  reg        battery_sense_uv_r;
  reg        power_fail_r;
  reg        battery_r;
  reg  [15:0] read_word;
  reg  [5:0] icl_code;
  wire [15:0] flags_word;

  wire scl_rise = scl_s && !scl_d_r;
  wire scl_fall = !scl_s && scl_d_r;
  wire start_ev = scl_s && scl_d_r && sda_d_r && !sda_s;
  wire stop_ev  = scl_s && scl_d_r && !sda_d_r && sda_s;

  assign flags_word = {adapter_present_flag_out, battery_r, power_fail_r, 13'h0000};

  // the applied code is recomputed from the stored word, so reads return what software wrote
  always @* begin
    // the 6-bit code tops out below the clamp point, so anything past its range saturates instead of wrapping
    if (icl_word_r > `ICL_MAX_MA || icl_word_r[15:13] != 3'h0) begin
      icl_code = `ICL_CODE_MAX;
    end else if (icl_word_r < `ICL_MIN_MA) begin
      icl_code = `ICL_CODE_MIN;
    end else begin
      icl_code = icl_word_r[`ICL_CODE_MSB:`ICL_CODE_LSB];
    end
  end

  always @* begin
    case (cmd_r)
      `CMD_INPUT_LIMIT: begin
        read_word = icl_word_r;
      end
      `CMD_STATE_FLAGS: begin
        read_word = flags_word;
      end
      `CMD_CHARGE_CURRENT: begin
        read_word = charge_current_word_out;
      end
      `CMD_CHARGE_VOLTAGE: begin
        read_word = charge_voltage_word_out;
      end
      `CMD_SPEC_INFO: begin
        read_word = `SPEC_INFO_VALUE;
      end
      default: begin
        read_word = 16'h0000;
      end
    endcase
  end

  // bus slave
  always @(posedge clk_in) begin
    if (rst) begin
      scl_d_r                 <= 1'b1;
      sda_d_r                 <= 1'b1;
      state_r                 <= ST_IDLE;
      bit_cnt_r               <= 4'h0;
      byte_idx_r              <= 2'h0;
      shift_r                 <= 8'h00;
      read_r                  <= 1'b0;
      hi_sent_r               <= 1'b0;
      mack_ok_r               <= 1'b0;
      cmd_r                   <= 8'h00;
      data_lo_r               <= 8'h00;
      tx_word_r               <= 16'h0000;
      sda_out                 <= 1'b0;
      sda_oe_out              <= 1'b0;
      icl_word_r              <= `ICL_RESET;
      charge_current_word_out <= `CHARGE_CURRENT_RESET;
      charge_voltage_word_out <= `CHARGE_VOLTAGE_RESET;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      sda_out <= 1'b0;
      if (stop_ev) begin
        state_r    <= ST_IDLE;
        sda_oe_out <= 1'b0;
      end else if (start_ev) begin
        state_r    <= ST_RX;
        bit_cnt_r  <= 4'h0;
        byte_idx_r <= 2'h0;
        sda_oe_out <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            sda_oe_out <= 1'b0;
          end
          ST_RX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_s};
              bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (scl_fall && bit_cnt_r == 4'h8) begin
              bit_cnt_r <= 4'h0;
              case (byte_idx_r)
                2'h0: begin
                  if (shift_r[7:1] == `SLAVE_ADDR) begin
                    read_r     <= shift_r[0];
                    sda_oe_out <= 1'b1;
                    state_r    <= ST_ACK;
                  end else begin
                    state_r <= ST_IDLE;
                  end
                end
                2'h1: begin
                  cmd_r      <= shift_r;
                  sda_oe_out <= 1'b1;
                  state_r    <= ST_ACK;
                end
                2'h2: begin
                  data_lo_r  <= shift_r;
                  sda_oe_out <= 1'b1;
                  state_r    <= ST_ACK;
                end
                default: begin
                  sda_oe_out <= 1'b1;
                  state_r    <= ST_ACK;
                end
              endcase
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              if (byte_idx_r == 2'h0 && read_r) begin
                // read-word: low byte first, msb of each byte first
                tx_word_r  <= read_word;
                shift_r    <= {read_word[6:0], 1'b0};
                sda_oe_out <= !read_word[7];
                bit_cnt_r  <= 4'h1;
                hi_sent_r  <= 1'b0;
                state_r    <= ST_TX;
              end else if (byte_idx_r == 2'h3) begin
                sda_oe_out <= 1'b0;
                state_r    <= ST_IDLE;
                // both bytes land together, only once the high byte is acknowledged
                case (cmd_r)
                  `CMD_INPUT_LIMIT: begin
                    icl_word_r <= {shift_r, data_lo_r};
                  end
                  `CMD_CHARGE_CURRENT: begin
                    charge_current_word_out <= {shift_r, data_lo_r};
                  end
                  `CMD_CHARGE_VOLTAGE: begin
                    charge_voltage_word_out <= {shift_r, data_lo_r};
                  end
                  default: begin
                    icl_word_r <= icl_word_r;
                  end
                endcase
              end else begin
                sda_oe_out <= 1'b0;
                byte_idx_r <= byte_idx_r + 2'h1;
                state_r    <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_r == 4'h8) begin
                sda_oe_out <= 1'b0;
                state_r    <= ST_MACK;
              end else begin
                sda_oe_out <= !shift_r[7];
                shift_r    <= {shift_r[6:0], 1'b0};
                bit_cnt_r  <= bit_cnt_r + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              mack_ok_r <= !sda_s;
            end else if (scl_fall) begin
              if (mack_ok_r && !hi_sent_r) begin
                hi_sent_r  <= 1'b1;
                shift_r    <= {tx_word_r[14:8], 1'b0};
                sda_oe_out <= !tx_word_r[15];
                bit_cnt_r  <= 4'h1;
                state_r    <= ST_TX;
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // status flags and converter controls
  always @(posedge clk_in) begin
    if (rst) begin
      battery_sense_uv_r                <= 1'b0;
      power_fail_r             <= 1'b0;
      battery_r                <= 1'b0;
      adapter_present_flag_out <= 1'b0;
      input_limit_code_out     <= `ICL_CODE_MIN;
      charge_limit_128ma_out   <= 1'b0;
      charge_enable_out        <= 1'b0;
      source_switch_drive_out  <= 1'b0;
    end else begin
      // hysteresis between 2.5V and 2.7V keeps the limit from chattering
      if (battery_sense_low_s) begin
        battery_sense_uv_r <= 1'b1;
      end else if (battery_sense_high_s) begin
        battery_sense_uv_r <= 1'b0;
      end
      power_fail_r             <= power_fail_s;
      battery_r                <= thermistor_s;
      adapter_present_flag_out <= adapter_ok_s;
      input_limit_code_out     <= icl_code;
      charge_limit_128ma_out   <= battery_sense_uv_r;
      charge_enable_out        <= adapter_ok_s && !power_fail_s;
      source_switch_drive_out  <= !power_fail_s;
    end
  end

endmodule

// [rtl/pin_sync.v]
// two-stage synchroniser for a group of asynchronous pin levels.
// assumes nothing of the source; the output is safe to read in the clk_in domain.
`timescale 1ns/1ps
module pin_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input  wire             clk_in,
  input  wire             reset_n_in,
  // levels
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_r;

  always @(posedge clk_in) begin
    if (!reset_n_in) begin
      meta_r   <= {WIDTH{1'b0}};
      sync_out <= {WIDTH{1'b0}};
    end else begin
      meta_r   <= async_in;
      sync_out <= meta_r;
    end
  end

endmodule

// [test/charger_monitor.sv]
// checker for the charger bus slave: bus answers, limit code and status outputs.
// assumes it is bound to the design top and sees its ports only.
`timescale 1ns/1ps
module charger_monitor (
  // clock and reset
  input wire logic       clk_in,
  input wire logic       reset_n_in,
  // inputs watched
  input wire logic       scl_in,
  input wire logic       adapter_above_7v5_in,
  input wire logic       adapter_below_battery_sense_in,
  input wire logic       battery_sense_below_2v5_in,
  input wire logic       vdd_under_2v5_in,
  // outputs checked
  input wire logic       sda_out,
  input wire logic       sda_oe_out,
  input wire logic [5:0] input_limit_code_out,
  input wire logic       charge_enable_out,
  input wire logic       source_switch_drive_out,
  input wire logic       adapter_present_flag_out,
  input wire logic       charge_limit_128ma_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  reset_code_a: assert property ($rose(reset_n_in) |-> input_limit_code_out == 6'h02)
    else $error("limit code not at default");
  vdd_quiet_a: assert property (vdd_under_2v5_in [*4] |=> !sda_oe_out && !charge_enable_out)
    else $error("active in supply undervoltage");
  vdd_por_a: assert property (vdd_under_2v5_in [*4] |=> input_limit_code_out == 6'h02)
    else $error("limit code kept in undervoltage");
  adapter_flag_a: assert property ((adapter_above_7v5_in && !vdd_under_2v5_in) [*6] |=> adapter_present_flag_out)
    else $error("adapter flag missing");
  power_fail_a: assert property ((adapter_below_battery_sense_in && !vdd_under_2v5_in) [*6]
    |=> !source_switch_drive_out && !charge_enable_out)
    else $error("switch on in power fail");
  battery_sense_uv_a: assert property ((battery_sense_below_2v5_in && !vdd_under_2v5_in) [*6] |=> charge_limit_128ma_out)
    else $error("no 128mA limit");
  sda_edge_a: assert property ($changed(sda_oe_out) |-> !scl_in)
    else $error("data moved with clock high");
  sda_drive_a: assert property (sda_oe_out |-> sda_out == 1'b0)
    else $error("data line driven high");
  cover property ($rose(sda_oe_out));
  cover property ($changed(input_limit_code_out));
  cover property ($fell(source_switch_drive_out));
endmodule
bind charger_smbus_limit_status charger_monitor i_charger_monitor (.*);

// [test/smbus_host_model.sv]
// two-wire bus host: word writes and reads, 320 ns bit period.
// assumes the bench resolves the open-drain data line with a pull-up.
`timescale 1ns/1ps
`include "charger_regs.vh"
module smbus_host_model (
  // clock
  input  wire logic clk_in,
  // bus
  input  wire logic sda_in,
  output logic      scl_out,
  output logic      sda_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  // quarter bit; lines move just after an edge
  task automatic q;
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    sda_out = b;
    q();
    scl_out = 1'b1;
    q();
    r = sda_in;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic start_c;
    sda_out = 1'b1;
    q();
    scl_out = 1'b1;
    q();
    sda_out = 1'b0;
    q();
    scl_out = 1'b0;
    q();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic m, output logic [7:0] r, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], b);
      r[i] = b;
    end
    bit_io(m, b);
    ack = !b;
  endtask
  // fewer than two data bytes aborts the word
  task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [15:0] d, input int n, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    k3 = 1'b1;
    k4 = 1'b1;
    start_c();
    byte_io({a, 1'b0}, 1'b1, r, k1);
    byte_io(c, 1'b1, r, k2);
    if (n > 0) byte_io(d[7:0], 1'b1, r, k3);
    if (n > 1) byte_io(d[15:8], 1'b1, r, k4);
    sda_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_out = 1'b1;
    q();
    ok = k1 & k2 & k3 & k4;
  endtask
  task automatic rd(input logic [7:0] c, output logic [15:0] d, output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    start_c();
    byte_io({`SLAVE_ADDR, 1'b0}, 1'b1, r, k1);
    byte_io(c, 1'b1, r, k2);
    start_c();
    byte_io({`SLAVE_ADDR, 1'b1}, 1'b1, r, k3);
    byte_io(8'hFF, 1'b0, d[7:0], k4);
    byte_io(8'hFF, 1'b1, d[15:8], k4);
    sda_out = 1'b0;
    q();
    scl_out = 1'b1;
    q();
    sda_out = 1'b1;
    q();
    ok = k1 & k2 & k3;
  endtask
endmodule

// [test/tb_top.sv]
// bench for the charger bus slave: limit decode, status flags, supply faults.
// assumes the host model drives the bus; released data is pulled high.
`timescale 1ns/1ps
`include "charger_regs.vh"
module tb_top;
  logic        clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic        above = 1'b0, below = 1'b0, therm = 1'b0, battery_sense_low = 1'b0, battery_sense_ok = 1'b1, vdd_low = 1'b0;
  wire         scl, sda_host, sda_oe, sda_drv, limit, en, sw, flag;
  wire  [5:0]  code;
  wire  [15:0] cur, volt;
  logic [15:0] d;
  logic        ok;
  int          errors = 0, compares = 0;
  // word written, applied code expected
  logic [21:0] rows [8] = '{{16'h0000, 6'h02}, {16'h00FF, 6'h02}, {16'h0100, 6'h02},
    {16'h0FFF, 6'h1F}, {16'h2AFD, 6'h3F}, {16'h2AFC, 6'h3F}, {16'h127F, 6'h24}, {16'h1234, 6'h24}};
  wire         sda_bus = sda_host & (sda_oe ? sda_drv : 1'b1);
  always #20 clk_in = ~clk_in;
  charger_smbus_limit_status i_charger_smbus_limit_status (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_drv), .sda_oe_out(sda_oe), .adapter_above_7v5_in(above),
    .adapter_below_battery_sense_in(below), .thermistor_below_91pct_in(therm), .battery_sense_below_2v5_in(battery_sense_low),
    .battery_sense_above_2v7_in(battery_sense_ok), .vdd_under_2v5_in(vdd_low), .input_limit_code_out(code),
    .charge_current_word_out(cur), .charge_voltage_word_out(volt), .charge_limit_128ma_out(limit),
    .charge_enable_out(en), .source_switch_drive_out(sw), .adapter_present_flag_out(flag));
  smbus_host_model i_smbus_host_model (.clk_in(clk_in), .sda_in(sda_bus), .scl_out(scl), .sda_out(sda_host));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #2000000;
    errors++;
    finish_test();
  end
  initial begin
    tick(3);
    reset_n_in = 1'b1;
    tick(4);
    chk(16'(code), 16'h0002);
    i_smbus_host_model.rd(`CMD_INPUT_LIMIT, d, ok);
    chk(d, `ICL_RESET);
    $display("reset test done");
    foreach (rows[i]) begin
      i_smbus_host_model.wr(`SLAVE_ADDR, `CMD_INPUT_LIMIT, rows[i][21:6], 2, ok);
      tick(4);
      chk(16'(code), 16'(rows[i][5:0]));
      i_smbus_host_model.rd(`CMD_INPUT_LIMIT, d, ok);
      chk(d, rows[i][21:6]);
    end
    $display("decode test done");
    i_smbus_host_model.wr(`SLAVE_ADDR, `CMD_INPUT_LIMIT, 16'h0FFF, 1, ok);
    i_smbus_host_model.wr(7'h0A, `CMD_INPUT_LIMIT, 16'h0FFF, 2, ok);
    chk(16'(ok), 16'h0000);
    tick(4);
    chk(16'(code), 16'h0024);
    i_smbus_host_model.wr(`SLAVE_ADDR, `CMD_CHARGE_VOLTAGE, 16'h0400, 2, ok);
    i_smbus_host_model.wr(`SLAVE_ADDR, `CMD_CHARGE_CURRENT, 16'h0800, 2, ok);
    above = 1'b1;
    therm = 1'b1;
    battery_sense_low = 1'b1;
    battery_sense_ok = 1'b0;
    tick(8);
    chk(volt, 16'h0400);
    chk({13'h0000, limit, en, sw}, 16'h0007);
    chk(cur, 16'h0800);
    i_smbus_host_model.rd(`CMD_STATE_FLAGS, d, ok);
    chk(d, 16'hC000);
    below = 1'b1;
    battery_sense_low = 1'b0;
    battery_sense_ok = 1'b1;
    tick(8);
    chk({13'h0000, limit, en, sw}, 16'h0000);
    i_smbus_host_model.rd(`CMD_STATE_FLAGS, d, ok);
    chk(d, 16'hE000);
    $display("status test done");
    vdd_low = 1'b1;
    tick(6);
    i_smbus_host_model.wr(`SLAVE_ADDR, `CMD_INPUT_LIMIT, 16'h0FFF, 2, ok);
    chk(16'(ok), 16'h0000);
    vdd_low = 1'b0;
    tick(6);
    chk(volt, 16'h0000);
    chk(cur, `CHARGE_CURRENT_RESET);
    i_smbus_host_model.rd(`CMD_INPUT_LIMIT, d, ok);
    chk(d, `ICL_RESET);
    $display("supply test done");
    finish_test();
  end
endmodule
